/* File: src/asc_consts.vh */
`ifndef ASC_CONSTS_VH
`define ASC_CONSTS_VH

`define ASC_ADDR_W 17
`define ASC_DATA_W 8
`define ASC_CNT_W 4
// times in ns at 20 ns clock period
`define ASC_CLK_NS 20
`define ASC_T_RC_NS 45
`define ASC_T_PWE_NS 35
`define ASC_T_SD_NS 25
`define ASC_T_HZ_NS 18
// least times round up to whole cycles
`define ASC_CYC(t) (((t) + `ASC_CLK_NS - 1) / `ASC_CLK_NS)
`define ASC_RD_CYC `ASC_CYC(`ASC_T_RC_NS + `ASC_CLK_NS)
`define ASC_WR_CYC `ASC_CYC(`ASC_T_PWE_NS)
`define ASC_SD_CYC `ASC_CYC(`ASC_T_SD_NS)
`define ASC_HZ_CYC `ASC_CYC(`ASC_T_HZ_NS)
`endif

/* File: src/asc_sync.v */
`timescale 1ns/1ns
// two-stage synchroniser for the data bus inputs
module asc_sync (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // data
    input wire [7:0] d,
    output reg [7:0] q
);
reg [7:0] meta_q;
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        meta_q <= 8'h00;
        q <= 8'h00;
    end else begin
        meta_q <= d;
        q <= meta_q;
    end
end
endmodule

/* File: src/asc_ctrl.v */
`timescale 1ns/1ns
`include "asc_consts.vh"
module asc_ctrl (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // user request
    input wire req,
    input wire req_write,
    input wire [16:0] req_addr,
    input wire [7:0] req_wdata,
    output reg req_ready,
    output reg rd_valid,
    output reg [7:0] rd_data,
    // memory pins
    output reg [16:0] mem_addr,
    output reg select_active_low_n,
    output reg select_active_high,
    output reg mem_we_n,
    output reg mem_oe_n,
    input wire [7:0] mem_dq_in,
    output reg [7:0] mem_dq_out,
    output reg mem_dq_oe_n
);
//////////////////////////////////////////////////////////////////////////////
localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_RD = 3'h1;
localparam [2:0] ST_RDEND = 3'h2;
localparam [2:0] ST_WR = 3'h3;
localparam [2:0] ST_WREND = 3'h4;
localparam [2:0] ST_TURN = 3'h5;
// cycle counts cut to the counter width on purpose
localparam integer RD_I = `ASC_RD_CYC;
localparam integer WR_I = `ASC_WR_CYC;
localparam integer SD_I = `ASC_SD_CYC;
localparam integer HZ_I = `ASC_HZ_CYC;
localparam [3:0] RD_CYC = RD_I[3:0];
localparam [3:0] WR_CYC = WR_I[3:0];
localparam [3:0] SD_CYC = SD_I[3:0];
localparam [3:0] HZ_CYC = HZ_I[3:0];

reg [2:0] st_q;
reg [3:0] cnt_q;
wire [7:0] dq_sync;

asc_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(mem_dq_in),
    .q(dq_sync)
);

//////////////////////////////////////////////////////////////////////////////
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        st_q <= ST_IDLE;
        cnt_q <= 4'h0;
        req_ready <= 1'b0;
        rd_valid <= 1'b0;
        rd_data <= 8'h00;
        mem_addr <= 17'h00000;
        select_active_low_n <= 1'b1;
        select_active_high <= 1'b0;
        mem_we_n <= 1'b1;
        mem_oe_n <= 1'b1;
        mem_dq_out <= 8'h00;
        mem_dq_oe_n <= 1'b1;
    end else begin
        rd_valid <= 1'b0;
        case (st_q)
        ST_IDLE: begin
            req_ready <= 1'b1;
            if (req && req_ready) begin
                req_ready <= 1'b0;
                // address before selects go active
                mem_addr <= req_addr;
                cnt_q <= 4'h0;
                if (req_write) begin
                    mem_dq_out <= req_wdata;
                    mem_oe_n <= 1'b1;
                    st_q <= ST_WR;
                end else begin
                    mem_we_n <= 1'b1;
                    mem_dq_oe_n <= 1'b1;
                    st_q <= ST_RD;
                end
            end
        end
        ST_RD: begin
            // select and oe active
            select_active_low_n <= 1'b0;
            select_active_high <= 1'b1;
            mem_oe_n <= 1'b0;
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == RD_CYC) begin
                rd_data <= dq_sync;
                rd_valid <= 1'b1;
                st_q <= ST_RDEND;
                cnt_q <= 4'h0;
            end
        end
        ST_RDEND: begin
            select_active_low_n <= 1'b1;
            select_active_high <= 1'b0;
            mem_oe_n <= 1'b1;
            st_q <= ST_TURN;
        end
        ST_WR: begin
            // both active together start the write
            select_active_low_n <= 1'b0;
            select_active_high <= 1'b1;
            mem_we_n <= 1'b0;
            mem_dq_oe_n <= 1'b0;
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q >= WR_CYC && cnt_q >= SD_CYC) begin
                // strobe ends the write; data held past it
                mem_we_n <= 1'b1;
                st_q <= ST_WREND;
                cnt_q <= 4'h0;
            end
        end
        ST_WREND: begin
            select_active_low_n <= 1'b1;
            select_active_high <= 1'b0;
            mem_dq_oe_n <= 1'b1;
            st_q <= ST_TURN;
        end
        ST_TURN: begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q >= HZ_CYC) begin
                cnt_q <= 4'h0;
                st_q <= ST_IDLE;
            end
        end
        default: st_q <= ST_IDLE;
        endcase
    end
end
endmodule

/* File: tb/asc_sram_model.sv */
`timescale 1ns/1ns
module asc_sram_model (
    // memory pins
    input wire [16:0] addr,
    input wire sl_n,
    input wire sh,
    input wire we_n,
    input wire oe_n,
    input wire [7:0] din,
    output wire [7:0] dq
);
    reg [7:0] mem [0:131071];
    reg [7:0] last = 8'h00;
    wire sel = !sl_n && sh;
    wire wr = sel && !we_n;
    wire rd = sel && we_n && !oe_n;
    // capture at whichever edge ends the overlap
    always @(negedge wr) mem[addr] = din;
    always @* if (rd) last = mem[addr];
    // released lines show the inverse of the last value
    assign dq = rd ? mem[addr] : ~last;
endmodule

/* File: tb/asc_ctrl_monitor.sv */
`timescale 1ns/1ns
module asc_ctrl_monitor (
    // watched ports
    input wire clk,
    input wire rst_n,
    input wire rd_valid,
    input wire [16:0] mem_addr,
    input wire select_active_low_n,
    input wire select_active_high,
    input wire mem_we_n,
    input wire mem_oe_n,
    input wire [7:0] mem_dq_out,
    input wire mem_dq_oe_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wr_start_a: assert property (!mem_we_n |-> !select_active_low_n
        && select_active_high && !mem_dq_oe_n) else $error("bad start");
    wr_end_a: assert property ($rose(mem_we_n) |=> select_active_low_n
        && mem_dq_oe_n) else $error("bad write end");
    wr_hold_a: assert property ($rose(mem_we_n) |-> !mem_dq_oe_n
        && $stable(mem_dq_out)) else $error("data not held");
    rd_strobe_a: assert property (!mem_oe_n |-> mem_we_n)
        else $error("strobe low in read");
    addr_early_a: assert property ($fell(select_active_low_n)
        |-> $stable(mem_addr)) else $error("late address");
    no_fight_a: assert property (!mem_oe_n |-> mem_dq_oe_n)
        else $error("bus contention");
    sel_firm_a: assert property (select_active_low_n !=
        select_active_high) else $error("selects disagree");
    cover property (rd_valid);
    cover property ($rose(mem_we_n));
    cover property (!mem_oe_n);
endmodule
bind asc_ctrl asc_ctrl_monitor mon (.clk, .rst_n, .rd_valid, .mem_addr,
    .select_active_low_n, .select_active_high, .mem_we_n, .mem_oe_n,
    .mem_dq_out, .mem_dq_oe_n);

/* File: tb/tb_async_sram_control_protocol.sv */
`timescale 1ns/1ns
module tb_async_sram_control_protocol;
    reg clk = 0, rst_n = 0, req = 0, rw = 0;
    reg [16:0] ra = 0;
    reg [7:0] rwd = 0;
    wire rdy, rv, sl_n, sh, we_n, oe_n, doe_n;
    wire [7:0] rdd, di, dout;
    wire [16:0] ma;
    integer fail_count = 0, n_checks = 0, i;
    asc_ctrl DUT (.clk, .rst_n, .req, .req_write(rw), .req_addr(ra),
        .req_wdata(rwd), .req_ready(rdy), .rd_valid(rv), .rd_data(rdd),
        .mem_addr(ma), .select_active_low_n(sl_n), .select_active_high(sh),
        .mem_we_n(we_n), .mem_oe_n(oe_n), .mem_dq_in(di),
        .mem_dq_out(dout), .mem_dq_oe_n(doe_n));
    asc_sram_model sram (.addr(ma), .sl_n, .sh, .we_n, .oe_n,
        .din(dout), .dq(di));
    initial forever #10 clk = ~clk;
    task stop_test; begin
        if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    end endtask
    task chk(input [95:0] nm, input [7:0] e, input [7:0] g); begin
        n_checks = n_checks + 1;
        if (g !== e) begin
            $display("[ERR] %0s exp %h got %h", nm, e, g);
            fail_count = fail_count + 1;
        end
    end endtask
    task wt(input sig_sel); begin
        i = 0;
        do begin @(posedge clk); i = i + 1; end
        while ((sig_sel ? rv : rdy) !== 1'b1 && i < 30);
        if (i >= 30) begin chk("timeout", 8'h01, 8'h00); stop_test; end
    end endtask
    // one transfer; for a read d is the expected byte
    task xfer(input w, input [16:0] a, input [7:0] d); begin
        req <= 1'b1; rw <= w; ra <= a; rwd <= d;
        wt(1'b0);
        req <= 1'b0;
        // let an edge pass so back-to-back writes never reassign req at once
        if (w) @(posedge clk);
        if (!w) begin wt(1'b1); chk("rd_data", d, rdd); end
    end endtask
    task t_wr_rd; begin
        xfer(1'b1, 17'h00012, 8'h5a);
        xfer(1'b0, 17'h00012, 8'h5a);
    end endtask
    task t_bounds; begin
        xfer(1'b1, 17'h1ffff, 8'ha5);
        xfer(1'b1, 17'h00000, 8'h3c);
        xfer(1'b0, 17'h1ffff, 8'ha5);
        xfer(1'b1, 17'h1ffff, 8'hc3);
        xfer(1'b0, 17'h00000, 8'h3c);
        xfer(1'b0, 17'h1ffff, 8'hc3);
    end endtask
    task t_idle; begin
        wt(1'b0);
        chk("idle pins", 8'h17, {3'h0, sl_n, sh, we_n, oe_n, doe_n});
    end endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_wr_rd;
        t_bounds;
        t_idle;
        stop_test;
    end
endmodule
